// ### rtl/sgc_global_ctrl.sv
// sgc_global_ctrl: global control bank of a five-port switch, with the scheduler,
// mirror match, storm limiter and uplink settings that those registers steer.
// assumes apb master on mclk, synchronous strap levels held stable around reset.
//
// Contract
// - two-bit priority field picks strict or 10:1, 5:1, 2:1 weighted service
// - code 00 always sends waiting high frame before any low frame
// - mirror mode 1: mirror only when source and destination both marked
// - mirror mode 0: mirror when source or destination marked; serves rx-only
// - bit 7 enables uplink half-duplex back pressure, resets to 0
// - bit 6 selects uplink half duplex, reset value from duplex strap
// - bit 5 enables uplink full-duplex flow control, reset from strap
// - bit 4 selects uplink 10 Mbit/s, reset from speed strap
// - bit 3 enables replacing zero vlan id with port vlan id
// - 11-bit storm budget: high three bits reg 6, low byte reg 7
// - budget counts 64-byte blocks accepted per input port per period
// - storm period 50 ms at 100 Mbit/s, 500 ms at 10 Mbit/s
// - storm limiting only on ports whose storm enable bit is set
`timescale 1ns/1ps
module sgc_global_ctrl
    import sgc_pkg::*;
#(
    parameter int NPORTS     = 5,
    parameter int PERIOD100  = SGC_PERIOD100_CYC,
    parameter int PERIOD10   = SGC_PERIOD10_CYC
)(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // strap levels
    input  wire logic              duplex_strap_pin,
    input  wire logic              flow_control_strap_pin,
    input  wire logic              speed_strap_pin,
    // egress scheduler request
    input  wire logic              sched_req,
    input  wire logic              hi_waiting,
    input  wire logic              lo_waiting,
    output logic                   sched_grant_hi,
    output logic                   sched_grant_lo,
    // mirror decision
    input  wire logic [NPORTS-1:0] mirror_rx_mark,
    input  wire logic [NPORTS-1:0] mirror_tx_mark,
    input  wire logic [NPORTS-1:0] frm_src,
    input  wire logic [NPORTS-1:0] frm_dst,
    output logic                   mirror_copy,
    // vlan id replacement
    input  wire logic [11:0]       rx_vid,
    input  wire logic [11:0]       port_vid,
    output logic [11:0]            vid_out,
    // storm limiter: one 64-byte block of broadcast data per strobe
    input  wire logic [NPORTS-1:0] bcast_blk,
    output logic [NPORTS-1:0]      storm_drop,
    // uplink settings
    output logic                   mii_backpressure_en,
    output logic                   mii_half_duplex,
    output logic                   mii_flow_ctrl_en,
    output logic                   mii_speed_10
);

    // assertion defaults, and a guard against sizes the 24-bit period timer cannot serve
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    if (NPORTS < 1 || NPORTS > 8 || PERIOD100 < 2 || PERIOD10 < PERIOD100
        || PERIOD10 > 24'hffffff)
    begin : gen_param_check
        $error("sgc_global_ctrl: unsupported parameters");
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [1:0]        prio_q, prio_d;
    logic              mirror_and_q, mirror_and_d;
    logic [7:0]        gc4_q, gc4_d;
    logic [7:0]        storm_lo_q, storm_lo_d;
    logic [NPORTS-1:0] port_storm_q, port_storm_d;
    logic              strap_done_q, strap_done_d;
    logic              pready_q, pready_d;
    logic [31:0]       prdata_q, prdata_d;
    logic              pslverr_q, pslverr_d;
    logic [NPORTS-1:0] storm_drop_q, storm_drop_d;

    // index decode shared by read and write paths
    function automatic logic idx_hit(input logic [11:0] a, input logic [7:0] idx);
        idx_hit = (a[1:0] == 2'h0) && (a[11:2] == {2'h0, idx});
    endfunction
    logic              acc, mapped;
    assign acc    = psel && penable && !pready_q;
    assign mapped = idx_hit(paddr, SGC_IDX_PRIO_MIRROR) || idx_hit(paddr, SGC_IDX_UPLINK_STORM)
                 || idx_hit(paddr, SGC_IDX_STORM_LOW) || idx_hit(paddr, SGC_IDX_PORT_STORM);

    // register file next state; straps caught on the first clock after reset release
    always_comb
    begin
        prio_d       = prio_q;
        mirror_and_d = mirror_and_q;
        gc4_d        = gc4_q;
        storm_lo_d   = storm_lo_q;
        port_storm_d = port_storm_q;
        strap_done_d = 1'b1;
        pready_d     = acc;
        pslverr_d    = acc && !mapped;
        prdata_d     = 32'h0;
        if (!strap_done_q)
        begin
            gc4_d[SGC_HALFDUP_BIT] = duplex_strap_pin;
            gc4_d[SGC_FLOWCTL_BIT] = flow_control_strap_pin;
            gc4_d[SGC_SPEED10_BIT] = speed_strap_pin;
        end
        if (acc && pwrite)
        begin
            if (idx_hit(paddr, SGC_IDX_PRIO_MIRROR))
            begin
                prio_d       = pwdata[SGC_PRIO_LSB +: 2];
                mirror_and_d = pwdata[SGC_MIRROR_BIT];
            end
            if (idx_hit(paddr, SGC_IDX_UPLINK_STORM))
                gc4_d = pwdata[7:0];
            if (idx_hit(paddr, SGC_IDX_STORM_LOW))
                storm_lo_d = pwdata[7:0];
            if (idx_hit(paddr, SGC_IDX_PORT_STORM))
                port_storm_d = pwdata[NPORTS-1:0];
        end
        if (acc && !pwrite)
        begin
            if (idx_hit(paddr, SGC_IDX_PRIO_MIRROR))
                prdata_d[7:0] = {4'h0, prio_q, 1'b0, mirror_and_q};
            if (idx_hit(paddr, SGC_IDX_UPLINK_STORM))
                prdata_d[7:0] = gc4_q;
            if (idx_hit(paddr, SGC_IDX_STORM_LOW))
                prdata_d[7:0] = storm_lo_q;
            if (idx_hit(paddr, SGC_IDX_PORT_STORM))
                prdata_d[NPORTS-1:0] = storm_drop_q;
        end
    end

    // register file flops; reset loads constants only
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            prio_q       <= SGC_PRIO_RST;
            mirror_and_q <= 1'b0;
            gc4_q        <= {5'h0, SGC_STORM_HI_RST};
            storm_lo_q   <= SGC_STORM_LO_RST;
            port_storm_q <= '0;
            strap_done_q <= 1'b0;
            pready_q     <= 1'b0;
            prdata_q     <= 32'h0;
            pslverr_q    <= 1'b0;
        end
        else
        begin
            prio_q       <= prio_d;
            mirror_and_q <= mirror_and_d;
            gc4_q        <= gc4_d;
            storm_lo_q   <= storm_lo_d;
            port_storm_q <= port_storm_d;
            strap_done_q <= strap_done_d;
            pready_q     <= pready_d;
            prdata_q     <= prdata_d;
            pslverr_q    <= pslverr_d;
        end
    end

    // ------------------------------------------------------------
    // scheduler, mirror, vlan and uplink outputs
    // ------------------------------------------------------------
    logic [3:0]        hi_cnt_q, hi_cnt_d;
    logic              gnt_hi_q, gnt_hi_d, gnt_lo_q, gnt_lo_d;
    logic              mirror_q, mirror_d;
    logic [11:0]       vid_q, vid_d;
    logic [3:0]        ratio;
    logic              src_m, dst_m;
    // weighted service: after ratio high grants a waiting low frame gets one turn
    always_comb
    begin
        case (prio_q)
            2'h1:    ratio = SGC_RATIO_01;
            2'h2:    ratio = SGC_RATIO_10;
            default: ratio = SGC_RATIO_11;
        endcase
        hi_cnt_d = hi_cnt_q;
        gnt_hi_d = 1'b0;
        gnt_lo_d = 1'b0;
        if (sched_req)
        begin
            if (prio_q == SGC_PRIO_STRICT)
            begin
                gnt_hi_d = hi_waiting;
                gnt_lo_d = !hi_waiting && lo_waiting;
            end
            else if (hi_waiting && (!lo_waiting || hi_cnt_q < ratio))
            begin
                gnt_hi_d = 1'b1;
                hi_cnt_d = (hi_cnt_q < ratio) ? hi_cnt_q + 4'h1 : hi_cnt_q;
            end
            else if (lo_waiting)
            begin
                gnt_lo_d = 1'b1;
                hi_cnt_d = 4'h0;
            end
        end
        src_m    = |(frm_src & mirror_rx_mark);
        dst_m    = |(frm_dst & mirror_tx_mark);
        mirror_d = mirror_and_q ? (src_m && dst_m)
                                : (src_m || dst_m);
        vid_d    = (gc4_q[SGC_NULLVID_BIT] && rx_vid == 12'h0) ? port_vid : rx_vid;
    end
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            hi_cnt_q <= 4'h0;
            gnt_hi_q <= 1'b0;
            gnt_lo_q <= 1'b0;
            mirror_q <= 1'b0;
            vid_q    <= 12'h0;
        end
        else
        begin
            hi_cnt_q <= hi_cnt_d;
            gnt_hi_q <= gnt_hi_d;
            gnt_lo_q <= gnt_lo_d;
            mirror_q <= mirror_d;
            vid_q    <= vid_d;
        end
    end

    // ------------------------------------------------------------
    // storm limiter
    // ------------------------------------------------------------
    // one shared period timer; its length follows the uplink speed bit
    logic [23:0]       tmr_q, tmr_d;
    logic [10:0]       blk_cnt_q [NPORTS];
    logic [10:0]       blk_cnt_d [NPORTS];
    logic [10:0]       budget;
    logic              period_end;
    logic [23:0]       period_len;
    assign budget     = {gc4_q[2:0], storm_lo_q};
    assign period_len = gc4_q[SGC_SPEED10_BIT] ? 24'(PERIOD10 - 1)
                                               : 24'(PERIOD100 - 1);
    assign period_end = (tmr_q >= period_len);
    always_comb
    begin
        tmr_d        = period_end ? 24'h0 : tmr_q + 24'h1;
        storm_drop_d = storm_drop_q;
        for (int p = 0; p < NPORTS; p++)
        begin
            blk_cnt_d[p] = blk_cnt_q[p];
            if (period_end)
            begin
                blk_cnt_d[p]    = 11'h0;
                storm_drop_d[p] = 1'b0;
            end
            else if (port_storm_q[p] && bcast_blk[p])
            begin
                if (blk_cnt_q[p] < budget)
                    blk_cnt_d[p] = blk_cnt_q[p] + 11'h1;
                else
                    storm_drop_d[p] = 1'b1;
            end
            if (!port_storm_q[p])
                storm_drop_d[p] = 1'b0;
        end
    end
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            tmr_q        <= 24'h0;
            storm_drop_q <= '0;
            for (int p = 0; p < NPORTS; p++)
                blk_cnt_q[p] <= 11'h0;
        end
        else
        begin
            tmr_q        <= tmr_d;
            storm_drop_q <= storm_drop_d;
            for (int p = 0; p < NPORTS; p++)
                blk_cnt_q[p] <= blk_cnt_d[p];
        end
    end

    // output wiring, all straight from flops
    assign pready              = pready_q;
    assign prdata              = prdata_q;
    assign pslverr             = pslverr_q;
    assign sched_grant_hi      = gnt_hi_q;
    assign sched_grant_lo      = gnt_lo_q;
    assign mirror_copy         = mirror_q;
    assign vid_out             = vid_q;
    assign storm_drop          = storm_drop_q;
    assign mii_backpressure_en = gc4_q[SGC_BACKPRES_BIT];
    assign mii_half_duplex     = gc4_q[SGC_HALFDUP_BIT];
    assign mii_flow_ctrl_en    = gc4_q[SGC_FLOWCTL_BIT];
    assign mii_speed_10        = gc4_q[SGC_SPEED10_BIT];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    strict_order_a: assert property (sched_req && prio_q == SGC_PRIO_STRICT && hi_waiting
        |=> gnt_hi_q && !gnt_lo_q) else $error("strict mode granted low ahead of high");
    mirror_and_a: assert property (mirror_and_q && !(src_m && dst_m) |=> !mirror_q)
        else $error("and-mode mirrored unmatched frame");
    mirror_or_a: assert property (!mirror_and_q && (src_m || dst_m) |=> mirror_q)
        else $error("or-mode missed a mirror");
    null_vid_a: assert property (gc4_q[SGC_NULLVID_BIT] && rx_vid == 12'h0
        |=> vid_q == $past(port_vid)) else $error("null vid not replaced");
    strap_dup_a: assert property (disable iff (1'b0) $fell(sys_rst)
        |=> mii_half_duplex == $past(duplex_strap_pin)) else $error("duplex strap not latched");
    storm_rst_a: assert property (disable iff (1'b0) sys_rst |=> budget == 11'h04a)
        else $error("storm budget reset wrong");
    storm_cap_a: assert property (!period_end && port_storm_q[0] && bcast_blk[0]
        && blk_cnt_q[0] >= budget |=> storm_drop_q[0]) else $error("budget overrun not dropped");
    storm_off_a: assert property (!port_storm_q[0] |=> !storm_drop_q[0])
        else $error("drop on disabled port");
    period_len_a: assert property (tmr_q <= period_len || $changed(period_len))
        else $error("period timer overran");
    ratio_a: assert property (hi_cnt_q <= SGC_RATIO_01)
        else $error("weighted counter out of range");

    lo_served_c: cover property (@(posedge mclk) prio_q != SGC_PRIO_STRICT && gnt_lo_q);
    drop_c:      cover property (@(posedge mclk) storm_drop_q[0]);
    mirror_c:    cover property (@(posedge mclk) mirror_and_q && mirror_q);

endmodule

// ### rtl/sgc_pkg.sv
// sgc_pkg: offsets, field positions, reset values and timing for the global control bank
// assumes a 10 MHz system clock and 32-bit apb access, one register per word
package sgc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] SGC_IDX_PRIO_MIRROR  = 8'h05;
    localparam logic [7:0] SGC_IDX_UPLINK_STORM = 8'h06;
    localparam logic [7:0] SGC_IDX_STORM_LOW    = 8'h07;
    localparam logic [7:0] SGC_IDX_PORT_STORM   = 8'h08; // port storm enables on write, drop flags on read, bits 4:0

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SGC_PRIO_LSB     = 2;
    localparam int SGC_MIRROR_BIT   = 0;
    localparam int SGC_BACKPRES_BIT = 7;
    localparam int SGC_HALFDUP_BIT  = 6;
    localparam int SGC_FLOWCTL_BIT  = 5;
    localparam int SGC_SPEED10_BIT  = 4;
    localparam int SGC_NULLVID_BIT  = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] SGC_PRIO_RST      = 2'h0;
    localparam logic [2:0] SGC_STORM_HI_RST  = 3'h0;
    localparam logic [7:0] SGC_STORM_LO_RST  = 8'h4a;

    // ------------------------------------------------------------
    // priority scheme codes and weighted ratios (high frames per low frame)
    // ------------------------------------------------------------
    localparam logic [1:0] SGC_PRIO_STRICT = 2'h0;
    localparam logic [3:0] SGC_RATIO_01    = 4'ha;
    localparam logic [3:0] SGC_RATIO_10    = 4'h5;
    localparam logic [3:0] SGC_RATIO_11    = 4'h2;

    // ------------------------------------------------------------
    // storm timing
    // ------------------------------------------------------------
    localparam int SGC_CLK_HZ        = 10_000_000;
    localparam int SGC_PERIOD100_MS  = 50;
    localparam int SGC_PERIOD10_MS   = 500;
    localparam int SGC_PERIOD100_CYC = SGC_CLK_HZ / 1000 * SGC_PERIOD100_MS;
    localparam int SGC_PERIOD10_CYC  = SGC_CLK_HZ / 1000 * SGC_PERIOD10_MS;
    localparam int SGC_BLOCK_BYTES   = 64;

endpackage

// ### dv/tb_switch_global_control_regs.sv
// tb_switch_global_control_regs: self-checking bench for the global control bank
// assumes sgc_pkg and sgc_global_ctrl compiled first; bench drives every port itself
`timescale 1ns/1ps
module tb_switch_global_control_regs
    import sgc_pkg::*;
;
    // short storm periods keep the run small; expectations follow these
    localparam int P100 = 20;
    localparam int P10  = 200;
    localparam int TMO  = 6000;

    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  w;
        logic [7:0]  r;
        logic        e;
    } sgc_row_s;

    // write value, then read back; unmapped and unaligned places answer with an error
    localparam sgc_row_s ROWS [8] = '{
        '{12'h014, 8'hff, 8'h0d, 1'b0}, '{12'h014, 8'h04, 8'h04, 1'b0},
        '{12'h018, 8'hff, 8'hff, 1'b0}, '{12'h018, 8'h2c, 8'h2c, 1'b0},
        '{12'h01c, 8'h00, 8'h00, 1'b0}, '{12'h01c, 8'ha5, 8'ha5, 1'b0},
        '{12'h040, 8'h33, 8'h00, 1'b1}, '{12'h016, 8'h33, 8'h00, 1'b1}};

    logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, rx_vid, port_vid, vid_out;
    logic [31:0] pwdata, prdata, rd;
    logic        duplex_strap_pin, flow_control_strap_pin, speed_strap_pin, er;
    logic        sched_req, hi_waiting, lo_waiting, sched_grant_hi, sched_grant_lo;
    logic [4:0]  mirror_rx_mark, mirror_tx_mark, frm_src, frm_dst, bcast_blk, storm_drop;
    logic        mirror_copy, mii_backpressure_en, mii_half_duplex, mii_flow_ctrl_en;
    logic        mii_speed_10;
    int          failures, num_checks, cyc;

    sgc_global_ctrl #(.NPORTS(5), .PERIOD100(P100), .PERIOD10(P10)) sgc_global_ctrl_inst (
        .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .duplex_strap_pin(duplex_strap_pin), .flow_control_strap_pin(flow_control_strap_pin),
        .speed_strap_pin(speed_strap_pin), .sched_req(sched_req), .hi_waiting(hi_waiting),
        .lo_waiting(lo_waiting), .sched_grant_hi(sched_grant_hi),
        .sched_grant_lo(sched_grant_lo), .mirror_rx_mark(mirror_rx_mark),
        .mirror_tx_mark(mirror_tx_mark), .frm_src(frm_src), .frm_dst(frm_dst),
        .mirror_copy(mirror_copy), .rx_vid(rx_vid), .port_vid(port_vid), .vid_out(vid_out),
        .bcast_blk(bcast_blk), .storm_drop(storm_drop),
        .mii_backpressure_en(mii_backpressure_en), .mii_half_duplex(mii_half_duplex),
        .mii_flow_ctrl_en(mii_flow_ctrl_en), .mii_speed_10(mii_speed_10));

    // ------------------------------------------------------------
    // clock, cycle count and hang guard
    // ------------------------------------------------------------
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    // a hang counts as a mismatch and ends in the common report
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == TMO)
        begin
            failures++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic check_cnt(input string nm, input int exp, input int got);
        num_checks++;
        if (got != exp)
        begin
            failures++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is sampled high at an edge,
    // answer taken at that edge; a slave that never answers runs into the hang guard
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // waits for port 0 drop flag to clear at a period end
    task automatic wait_fall();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (storm_drop[0] !== 1'b0 && n < 400);
        if (n >= 400)
            failures++;
    endtask

    // budget 3 on port 0 only; port 1 floods too but is not enabled
    task automatic storm_round(input int p);
        int n, t0;
        n = 0;
        @(posedge mclk);
        bcast_blk <= 5'h03;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (storm_drop[0] !== 1'b1 && n < 400);
        @(posedge mclk);
        bcast_blk <= 5'h00;
        wait_fall();
        t0 = cyc;
        @(posedge mclk);
        bcast_blk <= 5'h03;
        repeat (3) @(posedge mclk);
        #1;
        check_val("drop within budget", 32'h0, storm_drop);
        @(posedge mclk);
        bcast_blk <= 5'h00;
        #1;
        check_val("drop past budget", 32'h1, storm_drop);
        wait_fall();
        check_cnt("storm period", p, cyc - t0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int r, n, lows;
        {sys_rst, duplex_strap_pin, flow_control_strap_pin} <= 3'b111;
        {psel, penable, pwrite, speed_strap_pin, sched_req, hi_waiting, lo_waiting} <= 7'h0;
        {paddr, rx_vid, port_vid} <= 36'h0;
        pwdata <= 32'h0;
        {mirror_rx_mark, mirror_tx_mark, frm_src, frm_dst, bcast_blk} <= 25'h0;
        failures = 0;
        num_checks = 0;
        cyc = 0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        // reset values, straps caught into bits 6:4
        apb(1'b0, 12'h018, 32'h0);
        check_val("reg 0x06 reset", 32'h60, rd);
        apb(1'b0, 12'h014, 32'h0);
        check_val("reg 0x05 reset", 32'h0, rd);
        apb(1'b0, 12'h01c, 32'h0);
        check_val("reg 0x07 reset", 32'h4a, rd);
        check_val("uplink after reset", 32'h6, {mii_backpressure_en, mii_half_duplex,
                  mii_flow_ctrl_en, mii_speed_10});
        // register rows: write, read back, uplink bits follow reg 0x06
        foreach (ROWS[i])
        begin
            apb(1'b1, ROWS[i].a, {24'h0, ROWS[i].w});
            apb(1'b0, ROWS[i].a, 32'h0);
            check_val("row read", {23'h0, ROWS[i].r, ROWS[i].e}, {rd[30:0], er});
            if (ROWS[i].a == 12'h018)
                check_val("uplink bits", ROWS[i].w[7:4], {mii_backpressure_en,
                          mii_half_duplex, mii_flow_ctrl_en, mii_speed_10});
        end
        // mirror: source 0 marked rx, destination 2 marked tx, all combinations
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, 12'h014, m);
            for (int c = 0; c < 4; c++)
            begin
                @(posedge mclk);
                frm_src <= 5'h01;
                frm_dst <= 5'h04;
                mirror_rx_mark <= c[0] ? 5'h01 : 5'h00;
                mirror_tx_mark <= c[1] ? 5'h04 : 5'h00;
                @(posedge mclk);
                #1;
                check_val("mirror copy", m ? (c == 3) : (c != 0), mirror_copy);
            end
        end
        // scheduler: strict code over 12 requests, each weighted code over two full rounds
        for (int code = 0; code < 4; code++)
        begin
            apb(1'b1, 12'h014, code << 2);
            r = code == 1 ? SGC_RATIO_01 : code == 2 ? SGC_RATIO_10 : SGC_RATIO_11;
            n = code == 0 ? 12 : 2 * (r + 1);
            lows = 0;
            @(posedge mclk);
            {sched_req, hi_waiting, lo_waiting} <= 3'b111;
            repeat (n)
            begin
                @(posedge mclk);
                #1;
                lows += sched_grant_lo;
                check_val("one grant", 32'h1, sched_grant_hi ^ sched_grant_lo);
            end
            @(posedge mclk);
            sched_req <= 1'b0;
            check_cnt("low grants", code == 0 ? 0 : 2, lows);
        end
        @(posedge mclk);
        {sched_req, hi_waiting} <= 2'b10;
        @(posedge mclk);
        #1;
        check_val("low alone", 32'h1, sched_grant_lo);
        // null vid replacement off and on
        for (int e = 0; e < 2; e++)
        begin
            apb(1'b1, 12'h018, e << 3);
            @(posedge mclk);
            {sched_req, rx_vid, port_vid} <= {1'b0, 12'h000, 12'habc};
            @(posedge mclk);
            rx_vid <= 12'h123;
            #1;
            check_val("null vid", e ? 32'habc : 32'h0, vid_out);
            @(posedge mclk);
            #1;
            check_val("tagged vid", 32'h123, vid_out);
        end
        // storm limiter at both speeds
        apb(1'b1, 12'h018, 32'h0);
        apb(1'b1, 12'h01c, 32'h3);
        apb(1'b1, 12'h020, 32'h1);
        storm_round(P100);
        apb(1'b1, 12'h018, 32'h10);
        storm_round(P10);
        // second reset with other straps
        @(posedge mclk);
        {sys_rst, duplex_strap_pin, flow_control_strap_pin, speed_strap_pin} <= 4'b1001;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(1'b0, 12'h018, 32'h0);
        check_val("reg 0x06 restrap", 32'h10, rd);
        finish_test();
    end
endmodule
